/* rtl/fcms_consts.svh */
// constants for the forward channel mode select register bank
`ifndef FCMS_CONSTS_SVH
`define FCMS_CONSTS_SVH
`define FCMS_ADDR_MODE      8'h03
`define FCMS_ADDR_BCMODE    8'h04
`define FCMS_MODE_LSB       0
`define FCMS_MODE_MSB       2
`define FCMS_DONE_BIT       3
`define FCMS_OVR_BIT        4
`define FCMS_RSV6_BIT       6
`define FCMS_RSV7_BIT       7
`define FCMS_RSV5_BIT       5
`define FCMS_BCRSV_MSB      7
`define FCMS_BCRSV_LSB      3
`define FCMS_BLOCK_BIT      0
`define FCMS_RAW12_BIT      1
`define FCMS_RAW10_BIT      2
`define FCMS_OVR_RST        1'h0
`define FCMS_DONE_RST       1'h0
`define FCMS_BC_RST         3'h0
`define FCMS_MODE_RST       3'h0
`define FCMS_SETTLE_CYC     4'h3
`endif

/* rtl/fcms_pkg.sv */
// types for the forward channel mode select register bank
`default_nettype none
package fcms_pkg;
  typedef enum logic [2:0] {
    FCMS_MODE_CSI_SYNC  = 3'h0,
    FCMS_MODE_RSVD      = 3'h1,
    FCMS_MODE_CSI_EXT   = 3'h2,
    FCMS_MODE_CSI_AON   = 3'h3,
    FCMS_MODE_PAR_EXT   = 3'h5
  } fcms_mode_t;
  typedef enum logic [2:0] {
    FCMS_ST_DOWN   = 3'b001,
    FCMS_ST_SETTLE = 3'b010,
    FCMS_ST_DONE   = 3'b100
  } fcms_state_t;
endpackage
`default_nettype wire

/* rtl/fcms_sync.sv */
// two flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module fcms_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             clk,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_q;
  // refuse an empty synchroniser
  if (WIDTH < 1) begin : g_width_chk
    $error("fcms_sync needs WIDTH of at least 1");
  end
  // two stage capture
  always_ff @(posedge clk) begin
    s1_q <= d;
    q    <= s1_q;
  end
endmodule
`default_nettype wire

/* rtl/fcms_top.sv */
// forward channel mode select register bank
`timescale 1ns/10ps
`default_nettype none
`include "fcms_consts.svh"
module fcms_top (
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       SRST,
  // pins
  input  wire logic [2:0] MODE_STRAP,
  input  wire logic       RSV6_STRAP,
  input  wire logic       POWER_DOWN_BAR_PIN,
  // register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // back channel autoload
  input  wire logic       RX_LOCK,
  input  wire logic       BC_LOAD,
  input  wire logic       BC_RAW10,
  input  wire logic       BC_RAW12,
  // mode outputs
  output logic      [2:0] ACTIVE_MODE,
  output logic            MODE_LATCHED,
  output logic            PARALLEL_MODE,
  output logic            RAW10_PARALLEL_SELECT,
  output logic            RAW12_PARALLEL_SELECT
);
  logic [2:0] strap_s;
  logic       rsv6_s;
  logic       pdb_s;
  logic       pdb_prev_q;
  logic       pdb_rise;
  logic [2:0] strap_mode_q;
  logic       rsv6_q;
  logic [2:0] ovr_mode_q;
  logic       strap_override_enable_q;
  logic       rsv7_q;
  logic       rsv5_q;
  logic [4:0] bc_rsv_q;
  logic       raw10_parallel_select_q;
  logic       raw12_parallel_select_q;
  logic       parallel_autoload_block_q;
  logic [3:0] settle_q;
  logic       wr_mode;
  logic       wr_bc;
  logic       autoload;
  logic       pwr_up_q;
  fcms_pkg::fcms_state_t state_q;

  // pin synchronisers
  fcms_sync #(.WIDTH(5)) u_sync (
    .clk (SYS_CLK),
    .d   ({POWER_DOWN_BAR_PIN, RSV6_STRAP, MODE_STRAP}),
    .q   ({pdb_s, rsv6_s, strap_s})
  );

  assign wr_mode  = REG_WR && (REG_ADDR == `FCMS_ADDR_MODE);
  assign wr_bc    = REG_WR && (REG_ADDR == `FCMS_ADDR_BCMODE);
  assign pdb_rise = pdb_s && !pdb_prev_q;
  assign autoload = BC_LOAD && RX_LOCK && !parallel_autoload_block_q;

  // power-down edge tracking
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pdb_prev_q <= 1'b0;
      pwr_up_q   <= 1'b0;
    end else begin
      pdb_prev_q <= pdb_s;
      pwr_up_q   <= 1'b1;
    end
  end

  // strap capture
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      strap_mode_q <= `FCMS_MODE_RST;
      rsv6_q       <= 1'b0;
    end else if (!pwr_up_q) begin
      strap_mode_q <= strap_s;
      rsv6_q       <= rsv6_s;
    end else if (pdb_rise) begin
      strap_mode_q <= strap_s;
      rsv6_q       <= rsv6_s;
    end
  end

  // mode settle state machine
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q  <= fcms_pkg::FCMS_ST_DOWN;
      settle_q <= 4'h0;
    end else begin
      case (state_q)
        fcms_pkg::FCMS_ST_DOWN: begin
          settle_q <= 4'h0;
          if (pdb_rise) begin
            state_q <= fcms_pkg::FCMS_ST_SETTLE;
          end
        end
        fcms_pkg::FCMS_ST_SETTLE: begin
          if (!pdb_s) begin
            state_q <= fcms_pkg::FCMS_ST_DOWN;
          end else if (settle_q == `FCMS_SETTLE_CYC) begin
            state_q <= fcms_pkg::FCMS_ST_DONE;
          end else begin
            settle_q <= settle_q + 4'h1;
          end
        end
        fcms_pkg::FCMS_ST_DONE: begin
          if (!pdb_s) begin
            state_q <= fcms_pkg::FCMS_ST_DOWN;
          end
        end
        default: state_q <= fcms_pkg::FCMS_ST_DOWN;
      endcase
    end
  end

  // mode register writable bits
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      strap_override_enable_q <= `FCMS_OVR_RST;
      ovr_mode_q              <= `FCMS_MODE_RST;
      rsv7_q                  <= 1'b0;
      rsv5_q                  <= 1'b0;
    end else if (wr_mode) begin
      strap_override_enable_q <= REG_WDATA[`FCMS_OVR_BIT];
      rsv7_q                  <= REG_WDATA[`FCMS_RSV7_BIT];
      rsv5_q                  <= REG_WDATA[`FCMS_RSV5_BIT];
      if (REG_WDATA[`FCMS_OVR_BIT] || strap_override_enable_q) begin
        ovr_mode_q <= REG_WDATA[`FCMS_MODE_MSB:`FCMS_MODE_LSB];
      end
    end else if (!strap_override_enable_q) begin
      ovr_mode_q <= strap_mode_q;  // track strap until override
    end
  end

  // back channel mode register
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      parallel_autoload_block_q <= 1'b0;
      raw10_parallel_select_q   <= 1'b0;
      raw12_parallel_select_q   <= 1'b0;
      bc_rsv_q                  <= 5'h00;
    end else if (wr_bc) begin
      parallel_autoload_block_q <= REG_WDATA[`FCMS_BLOCK_BIT];
      raw10_parallel_select_q   <= REG_WDATA[`FCMS_RAW10_BIT];
      raw12_parallel_select_q   <= REG_WDATA[`FCMS_RAW12_BIT];
      bc_rsv_q                  <= REG_WDATA[`FCMS_BCRSV_MSB:`FCMS_BCRSV_LSB];
    end else if (autoload) begin
      raw10_parallel_select_q <= BC_RAW10;
      raw12_parallel_select_q <= BC_RAW12;
    end
  end

  assign ACTIVE_MODE   = strap_override_enable_q ? ovr_mode_q : strap_mode_q;
  assign MODE_LATCHED  = (state_q == fcms_pkg::FCMS_ST_DONE);
  assign PARALLEL_MODE = (ACTIVE_MODE == fcms_pkg::FCMS_MODE_PAR_EXT);
  assign RAW10_PARALLEL_SELECT = raw10_parallel_select_q;
  assign RAW12_PARALLEL_SELECT = raw12_parallel_select_q;

  // read mux
  always_comb begin
    REG_RDATA = 8'h00;
    if (REG_ADDR == `FCMS_ADDR_MODE) begin
      REG_RDATA = {rsv7_q, rsv6_q, rsv5_q, strap_override_enable_q, MODE_LATCHED, ACTIVE_MODE};
    end else if (REG_ADDR == `FCMS_ADDR_BCMODE) begin
      REG_RDATA = {bc_rsv_q, raw10_parallel_select_q, raw12_parallel_select_q,
                   parallel_autoload_block_q};
    end
  end

  // assertions
  a_done_reset: assert property (@(posedge SYS_CLK) $fell(SRST) |-> !MODE_LATCHED)
    else $error("latched flag set after reset");
  a_done_low_pin: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (!pdb_s && !$rose(pdb_s)) ##1 !pdb_s |-> !MODE_LATCHED)
    else $error("latched flag high while pin low");
  sequence s_rise_hold;
    pdb_rise ##1 pdb_s [*5];
  endsequence
  a_done_after_cap: assert property (@(posedge SYS_CLK) disable iff (SRST)
    s_rise_hold |-> MODE_LATCHED)
    else $error("latched flag did not set");
  a_capture_strap: assert property (@(posedge SYS_CLK) disable iff (SRST || !pwr_up_q)
    pdb_rise |=> strap_mode_q == $past(strap_s))
    else $error("strap not captured on rise");
  a_mode_readonly: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !strap_override_enable_q |-> ACTIVE_MODE == strap_mode_q)
    else $error("mode not strap when no override");
  a_mode_strap_only: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !strap_override_enable_q && !(wr_mode && REG_WDATA[`FCMS_OVR_BIT]) && !pdb_rise && pwr_up_q
    |=> $stable(ACTIVE_MODE))
    else $error("mode field changed without override");
  a_override_write: assert property (@(posedge SYS_CLK) disable iff (SRST)
    wr_mode && REG_WDATA[`FCMS_OVR_BIT]
    |=> ACTIVE_MODE == $past(REG_WDATA[`FCMS_MODE_MSB:`FCMS_MODE_LSB]))
    else $error("override write not applied");
  a_block_holds: assert property (@(posedge SYS_CLK) disable iff (SRST)
    parallel_autoload_block_q && !wr_bc |=> $stable(raw10_parallel_select_q)
    && $stable(raw12_parallel_select_q))
    else $error("autoload not blocked");
  a_raw10_load: assert property (@(posedge SYS_CLK) disable iff (SRST)
    autoload && !wr_bc |=> raw10_parallel_select_q == $past(BC_RAW10))
    else $error("raw10 not autoloaded");
  a_raw12_load: assert property (@(posedge SYS_CLK) disable iff (SRST)
    autoload && !wr_bc |=> raw12_parallel_select_q == $past(BC_RAW12))
    else $error("raw12 not autoloaded");
  a_par_decode: assert property (@(posedge SYS_CLK) disable iff (SRST)
    PARALLEL_MODE |-> ACTIVE_MODE == fcms_pkg::FCMS_MODE_PAR_EXT)
    else $error("parallel decode wrong");
endmodule
`default_nettype wire

/* dv/fcms_bc_model.sv */
// far-side back channel model: lock report and autoload strobe
`timescale 1ns/10ps
`default_nettype none
module fcms_bc_model (
  // clock
  input  wire logic clk,
  // autoload side
  output logic      rx_lock,
  output logic      bc_load,
  output logic      bc_raw10,
  output logic      bc_raw12
);
  // idle values
  initial begin
    rx_lock  = 1'h0;
    bc_load  = 1'h0;
    bc_raw10 = 1'h0;
    bc_raw12 = 1'h0;
  end
  task automatic load(input logic r10, input logic r12, input int gap);
    rx_lock  <= 1'h1;
    repeat (gap) @(posedge clk);
    bc_load  <= 1'h1;
    bc_raw10 <= r10;
    bc_raw12 <= r12;
    @(posedge clk);
    bc_load  <= 1'h0;
    bc_raw10 <= ~r10; // stale data shown inverted
    bc_raw12 <= ~r12;
  endtask
endmodule
`default_nettype wire

/* dv/fcms_top_test.sv */
// self-checking bench for the mode select bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(e, o) begin n_tests++; if ((o) !== (e)) begin err_total++; \
  $display("Error %0t: got %h exp %h", $time, o, e); end end
module fcms_top_test;
  logic       SYS_CLK, SRST, RSV6_STRAP, POWER_DOWN_BAR_PIN, REG_WR, look, r10e, r12e;
  logic [2:0] MODE_STRAP;
  logic [1:0] sel;
  logic [7:0] REG_ADDR, REG_WDATA, obs, e;
  logic [7:0] exp_q[$];
  logic [2:0] modes[4] = '{3'h5, 3'h0, 3'h2, 3'h3};
  int         err_total, n_tests, seed, r;
  wire  logic [7:0] REG_RDATA;
  wire  logic [2:0] ACTIVE_MODE;
  wire  logic       MODE_LATCHED, PARALLEL_MODE, RAW10_PARALLEL_SELECT, RAW12_PARALLEL_SELECT;
  wire  logic       RX_LOCK, BC_LOAD, BC_RAW10, BC_RAW12;
  fcms_top fcms_top_inst (.SYS_CLK, .SRST, .MODE_STRAP, .RSV6_STRAP, .POWER_DOWN_BAR_PIN, .REG_ADDR, .REG_WR,
    .REG_WDATA, .REG_RDATA, .RX_LOCK, .BC_LOAD, .BC_RAW10, .BC_RAW12, .ACTIVE_MODE, .MODE_LATCHED,
    .PARALLEL_MODE, .RAW10_PARALLEL_SELECT, .RAW12_PARALLEL_SELECT);
  fcms_bc_model fcms_bc_model_inst (.clk(SYS_CLK), .rx_lock(RX_LOCK), .bc_load(BC_LOAD), .bc_raw10(BC_RAW10),
    .bc_raw12(BC_RAW12));
  // observed value chosen by the driver
  always_comb obs = sel == 2'h2 ? {7'h00, MODE_LATCHED} : sel == 2'h1 ? {1'h0, ACTIVE_MODE, MODE_LATCHED,
    PARALLEL_MODE, RAW10_PARALLEL_SELECT, RAW12_PARALLEL_SELECT} : REG_RDATA;
  // oldest note against shown result
  always @(posedge SYS_CLK) begin
    if (look === 1'h1) begin
      e = exp_q.pop_front();
      `CHK(e, obs)
    end
  end
  task automatic note(input logic [7:0] v, input logic [1:0] s);
    exp_q.push_back(v);
    sel  <= s;
    look <= 1'h1;
    @(posedge SYS_CLK);
    look <= 1'h0;
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    REG_ADDR <= a;
    note(v, 2'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'h1;
    @(posedge SYS_CLK);
    REG_WR    <= 1'h0;
    @(posedge SYS_CLK);
  endtask
  function automatic logic [7:0] pack(input logic [2:0] m);
    return {1'h0, m, 1'h1, m == 3'h5, r10e, r12e};
  endfunction
  task automatic results;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // clock
  initial begin
    SYS_CLK = 1'h0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge SYS_CLK);
    err_total++;
    results();
  end
  // main sequence
  initial begin
    seed = 78829;
    SRST = 1'h1;
    MODE_STRAP = 3'h2;
    RSV6_STRAP = 1'h1;
    POWER_DOWN_BAR_PIN = 1'h0;
    REG_ADDR = 8'h00;
    REG_WR = 1'h0;
    REG_WDATA = 8'h00;
    sel = 2'h0;
    look = 1'h0;
    r10e = 1'h0;
    r12e = 1'h0;
    repeat (20) @(posedge SYS_CLK);
    SRST <= 1'h0;
    repeat (4) @(posedge SYS_CLK);
    rd(8'h03, 8'h42);
    rd(8'h04, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h03, 8'h05);
    rd(8'h03, 8'h42);
    foreach (modes[i]) begin
      MODE_STRAP <= modes[i];
      POWER_DOWN_BAR_PIN <= 1'h0;
      repeat (8) @(posedge SYS_CLK);
      note(8'h00, 2'h2);
      POWER_DOWN_BAR_PIN <= 1'h1;
      repeat (12) @(posedge SYS_CLK);
      MODE_STRAP <= ~modes[i];
      repeat (5) @(posedge SYS_CLK);
      note(pack(modes[i]), 2'h1);
    end
    wr(8'h03, 8'h15);
    note(pack(3'h5), 2'h1);
    wr(8'h03, 8'h00);
    rd(8'h03, 8'h4B);
    r = $random(seed);
    fcms_bc_model_inst.load(r[0], r[1], 0);
    r10e = r[0];
    r12e = r[1];
    note(pack(3'h3), 2'h1);
    wr(8'h04, 8'h05);
    fcms_bc_model_inst.load(1'h0, 1'h1, 3);
    rd(8'h04, 8'h05);
    wr(8'h04, 8'h00);
    fcms_bc_model_inst.load(r[2], r[3], 5);
    rd(8'h04, {5'h00, r[2], r[3], 1'h0});
    results();
  end
endmodule
`default_nettype wire
